// ==== holdover_map.svh ====
// Register offsets, field positions, reset values and counts for the
// holdover controller. Assumes inclusion by bare name from its users.
`ifndef HOLDOVER_MAP_SVH
`define HOLDOVER_MAP_SVH

// Register indices; byte address is four times the index
`define IDX_LOCKDET      8'h18
`define IDX_LDPIN        8'h1A
`define IDX_REFSEL       8'h1C
`define IDX_HOLDOVER     8'h1D
`define IDX_DISTCTL      8'h1E
`define IDX_STATUS       8'h20

// Lock detect register fields
`define LD_CNT_HI        6
`define LD_CNT_LO        5
`define LD_WIN_BIT       4
`define LD_DLD_DIS_BIT   3
`define LOCKDET_RST      8'h00

// Lock indicator pin select
`define LDPIN_W          6
`define LDPIN_CS_MODE    6'h04
`define LDPIN_RST        6'h00

// Reference selection fields
`define REF_AUTO_BIT     4
`define REF_PREF_BIT     3
`define REF_BUF_HI       2
`define REF_BUF_LO       1
`define REFSEL_RST       8'h00

// Holdover fields
`define HO_EN_A_BIT      0
`define HO_EXT_BIT       1
`define HO_EN_B_BIT      2
`define HO_CMP_BIT       3
`define HOLDOVER_RST     8'h00

// Distribution control: dividers ignore the control pin
`define DIST_IGN_BIT     0
`define DISTCTL_RST      8'h01

// Lock counts selected by the two-bit counter field
`define LOCK_CNT_0       8'd5
`define LOCK_CNT_1       8'd16
`define LOCK_CNT_2       8'd64
`define LOCK_CNT_3       8'd255

// Synchroniser bit positions and reset pattern
`define SY_PIN_N         0
`define SY_LOCKPIN       1
`define SY_FIRST_REFERENCE_INPUT          2
`define SY_SECOND_REFERENCE_INPUT          3
`define SY_ACT2          4
`define SY_WIN_HI        5
`define SY_WIN_LO        6
`define SY_UNLOCK        7
`define SY_W             8
`define SY_RST           8'h01

`endif

// ==== holdover_pkg.sv ====
// Types shared by the holdover controller.
// Assumes the constants header is compiled alongside.
`default_nettype none

package holdover_pkg;
  typedef enum logic [1:0] {HOLD_IDLE, HOLD_MANUAL, HOLD_AUTO} hold_src_t;
endpackage : holdover_pkg

`default_nettype wire

// ==== pll_holdover_control.sv ====
// PLL holdover control with lock sensing and reference selection, on APB.
// Assumes pin inputs are asynchronous and reference inputs are slow
// enough against pclk for their edges to be sampled.
//
// Function
// RULE1: Holdover acts only when both enable bits are set.
// RULE2: Source bit set selects the control pin, clear selects lock loss.
// RULE3: Manual mode enters high impedance on the pin falling edge.
// RULE4: After pin rises, stay frozen until next reference edge, then release.
// RULE5: B counter reset pulses with the release; prescaler untouched.
// RULE6: Automatic mode enters high impedance whenever lock is lost.
// RULE7: Automatic entry uses the lock indicator pin level.
// RULE8: Comparator disabled makes the lock indicator read as high.
// RULE9: Once entered, stays frozen while no reference edge arrives.
// RULE10: Automatic re-entry needs the lock indicator high again first.
// RULE11: Holdover follows the selected reference edges.
// RULE12: Two-bit counter sets in-window cycles to declare lock; 00 is five.
// RULE13: Window bit zero selects the high range.
// RULE14: Host keeps digital lock detect enabled for automatic holdover.
// RULE15: Pin select 000100b selects current-source lock detect mode.
// RULE16: Fields for auto switchover, preferred reference, input buffers.
// RULE17: Host disables holdover before a VCO calibration.
// RULE18: Manual holdover turns outputs off unless dividers ignore the pin.
// RULE19: Host should use current-source mode with automatic holdover.
// RULE20: Lock held until one cycle exceeds the unlock threshold.
// RULE21: One registered flag commands high impedance.
`timescale 1ns/10ps
`default_nettype none
`include "holdover_map.svh"

module pll_holdover_control
  import holdover_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic        pready,
  output var  logic [31:0] prdata,
  output var  logic        pslverr,
  input  wire logic        sync_pin_n,
  input  wire logic        lock_indicator_pin,
  input  wire logic        first_reference_input,
  input  wire logic        second_reference_input,
  input  wire logic        active_ref_second,
  input  wire logic        win_hi_ok,
  input  wire logic        win_lo_ok,
  input  wire logic        beyond_unlock,
  output var  logic        cp_hiz,
  output var  logic        b_cnt_reset,
  output var  logic        outputs_off,
  output var  logic        digital_lock_flag,
  output var  logic        dld_disable,
  output var  logic        lock_cs_mode,
  output var  logic [5:0]  ld_select,
  output var  logic        auto_switch_en,
  output var  logic        prefer_second,
  output var  logic [1:0]  ref_buf_en
);

  localparam int ADDR_W = 12;
  initial begin
    if (ADDR_W < 9) $error("Address too narrow for the register map");
  end

  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a[11:2] == {2'b00, idx}) && (a[1:0] == 2'b00);
  endfunction : hit

  function automatic logic [7:0] lock_need(input logic [1:0] f);
    unique case (f)
      2'b00: lock_need = `LOCK_CNT_0;
      2'b01: lock_need = `LOCK_CNT_1;
      2'b10: lock_need = `LOCK_CNT_2;
      2'b11: lock_need = `LOCK_CNT_3;
    endcase
  endfunction : lock_need

  logic [7:0]         lockdet_r;
  logic [5:0]         ldpin_r;
  logic [7:0]         refsel_r;
  logic [7:0]         holdover_r;
  logic [7:0]         distctl_r;
  logic               pready_r;
  logic               pslverr_r;
  logic [31:0]        prdata_r;
  logic [`SY_W-1:0]   meta_r;
  logic [`SY_W-1:0]   sync_r;
  logic [`SY_W-1:0]   sync_d_r;
  logic               cp_hiz_r;
  logic               b_rst_r;
  logic               out_off_r;
  logic               cs_mode_r;
  logic               armed_r;
  logic               dld_r;
  logic [7:0]         lk_cnt_r;
  hold_src_t          src_r;

  logic               wr_acc;
  logic               mapped;
  logic               hold_en;
  logic               ext_sel;
  logic               cmp_en;
  logic               lock_seen;
  logic               pin_fall;
  logic               pin_high;
  logic               use_second;
  logic               ref_edge;
  logic               in_win;
  logic               manual_set;
  logic               auto_set;
  logic               release_ev;

  // APB decode
  assign mapped = hit(paddr, `IDX_LOCKDET) | hit(paddr, `IDX_LDPIN)
                | hit(paddr, `IDX_REFSEL)  | hit(paddr, `IDX_HOLDOVER)
                | hit(paddr, `IDX_DISTCTL) | hit(paddr, `IDX_STATUS);
  assign wr_acc = psel && penable && pready_r && pwrite && mapped;

  // One wait state: answer on the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= psel && penable && !pready_r;
      pslverr_r <= psel && penable && !pready_r && !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_r <= 32'h0000_0000;
      if (hit(paddr, `IDX_LOCKDET))  prdata_r[7:0] <= lockdet_r;
      if (hit(paddr, `IDX_LDPIN))    prdata_r[5:0] <= ldpin_r;
      if (hit(paddr, `IDX_REFSEL))   prdata_r[7:0] <= refsel_r;
      if (hit(paddr, `IDX_HOLDOVER)) prdata_r[7:0] <= holdover_r;
      if (hit(paddr, `IDX_DISTCTL))  prdata_r[7:0] <= distctl_r;
      if (hit(paddr, `IDX_STATUS)) begin
        prdata_r[5:0] <= {src_r == HOLD_AUTO, src_r == HOLD_MANUAL,
                          armed_r, lock_seen, dld_r, cp_hiz_r};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lockdet_r  <= `LOCKDET_RST;
      ldpin_r    <= `LDPIN_RST;
      refsel_r   <= `REFSEL_RST;
      holdover_r <= `HOLDOVER_RST;
      distctl_r  <= `DISTCTL_RST;
      cs_mode_r  <= 1'b0;
    end else if (wr_acc) begin
      if (hit(paddr, `IDX_LOCKDET))  lockdet_r  <= pwdata[7:0];
      if (hit(paddr, `IDX_LDPIN))    ldpin_r    <= pwdata[5:0];
      if (hit(paddr, `IDX_LDPIN)) cs_mode_r <= pwdata[5:0] == `LDPIN_CS_MODE;
      if (hit(paddr, `IDX_REFSEL))   refsel_r   <= pwdata[7:0];
      if (hit(paddr, `IDX_HOLDOVER)) holdover_r <= pwdata[7:0];
      if (hit(paddr, `IDX_DISTCTL))  distctl_r  <= pwdata[7:0];
    end
  end

  // Two-flop synchronisers; third stage only for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r   <= `SY_RST;
      sync_r   <= `SY_RST;
      sync_d_r <= `SY_RST;
    end else begin
      meta_r   <= {beyond_unlock, win_lo_ok, win_hi_ok, active_ref_second,
                   second_reference_input, first_reference_input,
                   lock_indicator_pin, sync_pin_n};
      sync_r   <= meta_r;
      sync_d_r <= sync_r;
    end
  end

  assign hold_en   = holdover_r[`HO_EN_A_BIT] & holdover_r[`HO_EN_B_BIT]; // RULE1
  assign ext_sel   = holdover_r[`HO_EXT_BIT]; // RULE2
  assign cmp_en    = holdover_r[`HO_CMP_BIT];
  assign lock_seen = !cmp_en | sync_r[`SY_LOCKPIN]; // RULE7 RULE8
  assign pin_fall  = sync_d_r[`SY_PIN_N] & !sync_r[`SY_PIN_N];
  assign pin_high  = sync_r[`SY_PIN_N];
  // Switchover logic outside picks the live reference when auto is on
  assign use_second = refsel_r[`REF_AUTO_BIT] ? sync_r[`SY_ACT2]
                                              : refsel_r[`REF_PREF_BIT];
  assign ref_edge  = use_second
                   ? (sync_r[`SY_SECOND_REFERENCE_INPUT] & !sync_d_r[`SY_SECOND_REFERENCE_INPUT])
                   : (sync_r[`SY_FIRST_REFERENCE_INPUT] & !sync_d_r[`SY_FIRST_REFERENCE_INPUT]); // RULE11
  assign in_win    = lockdet_r[`LD_WIN_BIT] ? sync_r[`SY_WIN_LO]
                                            : sync_r[`SY_WIN_HI]; // RULE13

  assign manual_set = hold_en & ext_sel & pin_fall; // RULE3
  assign auto_set   = hold_en & !ext_sel & !lock_seen & armed_r; // RULE6
  // Manual release also waits for the pin to be back high
  assign release_ev = cp_hiz_r & ref_edge
                    & ((src_r != HOLD_MANUAL) | pin_high); // RULE4 RULE9

  // Digital lock detector, counted on reference edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dld_r    <= 1'b0;
      lk_cnt_r <= 8'h00;
    end else if (lockdet_r[`LD_DLD_DIS_BIT]) begin
      dld_r    <= 1'b0;
      lk_cnt_r <= 8'h00;
    end else if (ref_edge) begin
      if (dld_r) begin
        if (sync_r[`SY_UNLOCK]) begin
          dld_r    <= 1'b0; // RULE20
          lk_cnt_r <= 8'h00;
        end
      end else if (in_win) begin
        if (lk_cnt_r + 8'h01 >= lock_need(lockdet_r[6:5])) begin
          dld_r    <= 1'b1; // RULE12
          lk_cnt_r <= 8'h00;
        end else begin
          lk_cnt_r <= lk_cnt_r + 8'h01;
        end
      end else begin
        lk_cnt_r <= 8'h00;
      end
    end
  end

  // Single freeze flag; entry wins over a same-cycle release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cp_hiz_r <= 1'b0;
      src_r    <= HOLD_IDLE;
    end else if (!hold_en) begin
      cp_hiz_r <= 1'b0; // RULE1
      src_r    <= HOLD_IDLE;
    end else if (manual_set) begin
      cp_hiz_r <= 1'b1; // RULE21
      src_r    <= HOLD_MANUAL;
    end else if (auto_set) begin
      cp_hiz_r <= 1'b1; // RULE21
      src_r    <= HOLD_AUTO;
    end else if (release_ev) begin
      cp_hiz_r <= 1'b0; // RULE4
      src_r    <= HOLD_IDLE;
    end
  end

  // B counter reset coincides with the release edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_rst_r <= 1'b0;
    end else begin
      b_rst_r <= hold_en & release_ev & !manual_set & !auto_set; // RULE5
    end
  end

  // Chatter on the indicator cannot retrigger until lock is seen again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_r <= 1'b0;
    end else if (auto_set) begin
      armed_r <= 1'b0;
    end else if (!cp_hiz_r && lock_seen) begin
      armed_r <= 1'b1; // RULE10
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_off_r <= 1'b0;
    end else begin
      out_off_r <= hold_en & ext_sel & !distctl_r[`DIST_IGN_BIT]
                 & (manual_set | (cp_hiz_r & src_r == HOLD_MANUAL
                    & !release_ev)); // RULE18
    end
  end

  assign pready            = pready_r;
  assign pslverr           = pslverr_r;
  assign prdata            = prdata_r;
  assign cp_hiz            = cp_hiz_r;
  assign b_cnt_reset       = b_rst_r;
  assign outputs_off       = out_off_r;
  assign digital_lock_flag = dld_r;
  assign dld_disable       = lockdet_r[`LD_DLD_DIS_BIT];
  assign ld_select         = ldpin_r;
  assign lock_cs_mode      = cs_mode_r; // RULE15
  assign auto_switch_en    = refsel_r[`REF_AUTO_BIT]; // RULE16
  assign prefer_second     = refsel_r[`REF_PREF_BIT];
  assign ref_buf_en        = refsel_r[`REF_BUF_HI:`REF_BUF_LO];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_disabled;
    !hold_en |=> !cp_hiz_r;
  endproperty
  a_disabled: assert property (p_disabled) // RULE1
    else $error("Charge pump frozen while holdover disabled");
  property p_src;
    $rose(cp_hiz_r) && src_r == HOLD_MANUAL |-> $past(ext_sel);
  endproperty
  a_src: assert property (p_src) // RULE2
    else $error("Manual entry without external source");
  property p_manual;
    manual_set |=> cp_hiz_r && src_r == HOLD_MANUAL;
  endproperty
  a_manual: assert property (p_manual) // RULE3
    else $error("Pin falling edge did not freeze");

  property p_pin_low;
    hold_en && cp_hiz_r && src_r == HOLD_MANUAL && !pin_high |=> cp_hiz_r;
  endproperty
  a_pin_low: assert property (p_pin_low) // RULE4
    else $error("Released while control pin low");

  property p_brst;
    $fell(cp_hiz_r) && $past(hold_en) |-> b_rst_r;
  endproperty
  a_brst: assert property (p_brst) // RULE5
    else $error("B counter reset missing at release");

  property p_auto;
    auto_set |=> cp_hiz_r ##0 !armed_r;
  endproperty
  a_auto: assert property (p_auto) // RULE6
    else $error("Lock loss did not freeze");
  property p_cmp;
    !cmp_en && !ext_sel && !cp_hiz_r |=> !cp_hiz_r;
  endproperty
  a_cmp: assert property (p_cmp) // RULE8
    else $error("Disabled comparator not read as high");

  property p_noref;
    hold_en && cp_hiz_r && !ref_edge |=> cp_hiz_r;
  endproperty
  a_noref: assert property (p_noref) // RULE9
    else $error("Released without a reference edge");

  property p_rearm;
    !armed_r && !lock_seen |=> !armed_r;
  endproperty
  a_rearm: assert property (p_rearm) // RULE10
    else $error("Rearmed without lock seen");

  property p_dld_hold;
    dld_r && !lockdet_r[`LD_DLD_DIS_BIT] && !(ref_edge && sync_r[`SY_UNLOCK])
      |=> dld_r;
  endproperty
  a_dld_hold: assert property (p_dld_hold) // RULE20
    else $error("Lock dropped without unlock cycle");

  property p_apb;
    psel && penable && !pready_r |=> pready_r ##1 !pready_r;
  endproperty
  a_apb: assert property (p_apb)
    else $error("APB answer not one wait state");

  c_manual: cover property (manual_set ##[1:200] b_rst_r);
  c_auto: cover property (auto_set ##[1:200] b_rst_r);
  c_lock: cover property ($rose(dld_r));
  c_off: cover property ($rose(out_off_r));

endmodule : pll_holdover_control

`default_nettype wire

// ==== ref_source.sv ====
// Far-side model: host logic that supplies the two reference clocks.
// Assumes one pclk domain; a reference stands low while not running.
`timescale 1ns/10ps
`default_nettype none

module ref_source (
  input  wire logic pclk,
  input  wire logic run_a,
  input  wire logic run_b,
  output var  logic first_reference_input,
  output var  logic second_reference_input
);
  logic [2:0] phase_r = 3'h0;

  always_ff @(posedge pclk) begin
    phase_r <= phase_r + 3'h1;
  end

  // Period of 16 pclk keeps every edge well inside the sampling limit
  always_ff @(posedge pclk) begin
    if (!run_a) begin
      first_reference_input <= 1'h0;
    end else if (phase_r == 3'h7) begin
      first_reference_input <= ~first_reference_input;
    end
  end

  // Offset phase so the two references never move together
  always_ff @(posedge pclk) begin
    if (!run_b) begin
      second_reference_input <= 1'h0;
    end else if (phase_r == 3'h3) begin
      second_reference_input <= ~second_reference_input;
    end
  end
endmodule : ref_source

`default_nettype wire

// ==== test_pll_holdover_control.sv ====
// Self-checking bench for the PLL holdover controller over APB.
// Assumes the reference source model drives both reference inputs.
`timescale 1ns/10ps
`default_nettype none
`include "holdover_map.svh"

module test_pll_holdover_control import holdover_pkg::*; ;
  localparam logic [11:0] a_ld   = {2'h0, `IDX_LOCKDET, 2'h0};
  localparam logic [11:0] a_pin  = {2'h0, `IDX_LDPIN, 2'h0};
  localparam logic [11:0] a_ref  = {2'h0, `IDX_REFSEL, 2'h0};
  localparam logic [11:0] a_ho   = {2'h0, `IDX_HOLDOVER, 2'h0};
  localparam logic [11:0] a_dist = {2'h0, `IDX_DISTCTL, 2'h0};
  localparam logic [11:0] a_st   = {2'h0, `IDX_STATUS, 2'h0};

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        rerr, sync_pin_n, lock_indicator_pin, run_a, run_b;
  logic        first_reference_input, second_reference_input;
  logic        active_ref_second, win_hi_ok, win_lo_ok, beyond_unlock;
  logic        cp_hiz, b_cnt_reset, outputs_off, digital_lock_flag;
  logic        dld_disable, lock_cs_mode, auto_switch_en, prefer_second;
  logic [5:0]  ld_select;
  logic [1:0]  ref_buf_en;
  int          miscompares, samples_checked;

  pll_holdover_control dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .sync_pin_n, .lock_indicator_pin,
    .first_reference_input, .second_reference_input, .active_ref_second,
    .win_hi_ok, .win_lo_ok, .beyond_unlock, .cp_hiz, .b_cnt_reset,
    .outputs_off, .digital_lock_flag, .dld_disable, .lock_cs_mode,
    .ld_select, .auto_switch_en, .prefer_second, .ref_buf_en
  );

  ref_source ref_u (
    .pclk, .run_a, .run_b, .first_reference_input, .second_reference_input
  );

  always #5 pclk = ~pclk;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  task automatic hang();
    miscompares++;
    report_and_stop();
  endtask : hang

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : wt

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    #1;
    for (n = 0; pready !== 1'h1; n++) begin
      if (n == 20) hang();
      wt(1);
    end
    rdat = prdata;
    rerr = pslverr;
    @(posedge pclk);
    psel    <= 1'h0;
    penable <= 1'h0;
    #1;
  endtask : apb

  // Steps one cycle at a time so a one-cycle level is never missed
  task automatic wait_hiz(input logic v, input int lim);
    int n;
    #1;
    for (n = 0; cp_hiz !== v; n++) begin
      if (n == lim) hang();
      wt(1);
    end
    samples_checked++;
  endtask : wait_hiz

  task automatic edges(input int cnt);
    int   k;
    int   n;
    logic p;
    k = 0;
    p = first_reference_input;
    for (n = 0; k < cnt; n++) begin
      if (n == 400) hang();
      wt(1);
      if (first_reference_input === 1'h1 && p === 1'h0) k++;
      p = first_reference_input;
    end
    wt(6);
  endtask : edges

  task automatic s_regs();
    apb(1'h0, a_ld, 32'h0);
    chk("lockdet", rdat, 32'h0);
    apb(1'h0, a_pin, 32'h0);
    chk("ldpin", rdat, 32'h0);
    apb(1'h0, a_ho, 32'h0);
    chk("holdover", rdat, 32'h0);
    apb(1'h0, a_dist, 32'h0);
    chk("distctl", rdat, 32'h1);
    apb(1'h0, 12'h07C, 32'h0);
    chk("slverr", rerr, 32'h1);
    apb(1'h1, a_ref, 32'h1E);
    chk("rf", {auto_switch_en, prefer_second, ref_buf_en}, 32'hF);
    apb(1'h1, a_pin, 32'h4);
    chk("csmode", lock_cs_mode, 32'h1);
    apb(1'h1, a_pin, 32'h5);
    chk("ldsel", {lock_cs_mode, ld_select}, 32'h5);
    apb(1'h1, a_ld, 32'h8);
    chk("dld_dis", dld_disable, 32'h1);
    apb(1'h1, a_ld, 32'h0);
  endtask : s_regs

  task automatic s_manual();
    apb(1'h1, a_dist, 32'h0);
    @(posedge pclk) sync_pin_n <= 1'h0;
    wt(10);
    apb(1'h1, a_ho, 32'h7);
    wt(10);
    chk("lvl", cp_hiz, 32'h0);
    @(posedge pclk) sync_pin_n <= 1'h1;
    active_ref_second <= 1'h1;
    wt(10);
    @(posedge pclk) sync_pin_n <= 1'h0;
    wait_hiz(1'h1, 8);
    chk("off", outputs_off, 32'h1);
    @(posedge pclk) run_b <= 1'h1;
    wt(40);
    chk("pin_low", cp_hiz, 32'h1);
    @(posedge pclk) run_b <= 1'h0;
    wt(4);
    @(posedge pclk) sync_pin_n <= 1'h1;
    run_a <= 1'h1;
    wt(60);
    chk("other_ref", cp_hiz, 32'h1);
    @(posedge pclk) run_b <= 1'h1;
    wait_hiz(1'h0, 40);
    chk("brst", b_cnt_reset, 32'h1);
    chk("on", outputs_off, 32'h0);
    wt(1);
    chk("brst_end", b_cnt_reset, 32'h0);
    @(posedge pclk) run_b <= 1'h0;
    active_ref_second <= 1'h0;
    apb(1'h1, a_dist, 32'h1);
    apb(1'h1, a_ho, 32'h0);
  endtask : s_manual

  task automatic s_lock();
    edges(1);
    @(posedge pclk) win_hi_ok <= 1'h1;
    edges(4);
    chk("lock4", digital_lock_flag, 32'h0);
    edges(1);
    chk("lock5", digital_lock_flag, 32'h1);
    @(posedge pclk) win_hi_ok <= 1'h0;
    edges(2);
    chk("hold", digital_lock_flag, 32'h1);
    @(posedge pclk) beyond_unlock <= 1'h1;
    edges(1);
    chk("unlock", digital_lock_flag, 32'h0);
    @(posedge pclk) beyond_unlock <= 1'h0;
    apb(1'h1, a_ld, 32'h10);
    @(posedge pclk) win_hi_ok <= 1'h1;
    edges(6);
    chk("lo_rng", digital_lock_flag, 32'h0);
    @(posedge pclk) win_lo_ok <= 1'h1;
    edges(6);
    chk("lo_lock", digital_lock_flag, 32'h1);
    apb(1'h1, a_ld, 32'h0);
  endtask : s_lock

  task automatic s_auto();
    apb(1'h1, a_ref, 32'h6);
    chk("rsel", {auto_switch_en, prefer_second, ref_buf_en}, 32'h3);
    @(posedge pclk) active_ref_second <= 1'h1;
    apb(1'h1, a_pin, 32'h4);
    apb(1'h1, a_ho, 32'hD);
    wt(10);
    chk("idle", cp_hiz, 32'h0);
    @(posedge pclk) run_a <= 1'h0;
    lock_indicator_pin <= 1'h0;
    wait_hiz(1'h1, 8);
    apb(1'h0, a_st, 32'h0);
    chk("st", rdat[0], 32'h1);
    wt(40);
    chk("noref", cp_hiz, 32'h1);
    @(posedge pclk) run_a <= 1'h1;
    wait_hiz(1'h0, 40);
    chk("brst", b_cnt_reset, 32'h1);
    wt(40);
    chk("rearm", cp_hiz, 32'h0);
    @(posedge pclk) lock_indicator_pin <= 1'h1;
    wt(10);
    @(posedge pclk) lock_indicator_pin <= 1'h0;
    wait_hiz(1'h1, 8);
    wait_hiz(1'h0, 40);
    apb(1'h1, a_ho, 32'h5);
    @(posedge pclk) lock_indicator_pin <= 1'h1;
    wt(10);
    @(posedge pclk) lock_indicator_pin <= 1'h0;
    wt(20);
    chk("cmp_off", cp_hiz, 32'h0);
    apb(1'h1, a_ho, 32'h0);
  endtask : s_auto

  initial begin
    miscompares = 0;
    samples_checked = 0;
    pclk = 1'h0;
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    sync_pin_n = 1'h1;
    lock_indicator_pin = 1'h1;
    run_a = 1'h0;
    run_b = 1'h0;
    active_ref_second = 1'h0;
    win_hi_ok = 1'h0;
    win_lo_ok = 1'h0;
    beyond_unlock = 1'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    s_regs();
    s_manual();
    s_lock();
    s_auto();
    report_and_stop();
  end
endmodule : test_pll_holdover_control

`default_nettype wire
